/* File: rtl/sswc_pkg.sv */
/*
 * Shared constants and types for the standby stop/wait controller.
 * Assumes one 250 MHz system clock and 32-bit AXI4-Lite registers.
 */
package sswc_pkg;

	// ******************************
	// register map
	// ******************************
	localparam logic [7:0] MISC_OFS   = 8'h00;
	localparam logic [7:0] CMODE_OFS  = 8'h04;
	localparam logic [7:0] TLATCH_OFS = 8'h08;
	localparam logic [7:0] STAT_OFS   = 8'h0C;

	localparam int STAB_SEL_BIT  = 0;
	localparam int CM_MAIN_STOP  = 0;
	localparam int CM_SUB_EN     = 1;
	localparam int CM_SUB_SEL    = 2;
	localparam int TL_PRESC_LSB  = 0;
	localparam int TL_TIMER_LSB  = 8;

	localparam logic       MISC_RST  = 1'b0;
	localparam logic [2:0] CMODE_RST = 3'h0;

	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ******************************
	// timing, in main oscillator cycles
	// ******************************
	localparam logic [7:0] STOP_PRESC_LOAD = 8'hFF;
	localparam logic [7:0] STOP_TIMER_LOAD = 8'h01;
	localparam logic [3:0] PRESC_DIV_LAST  = 4'hF;
	localparam int STAB_XIN_APPROX    = 8000;
	localparam int RST_HOLD_MIN_XIN   = 20;
	localparam int RST_REL_MIN_TENTHS = 105;
	localparam int RST_REL_MAX_TENTHS = 185;
	localparam logic [4:0] RST_REL_XIN = 5'h0E;

	typedef enum logic [5:0] {
		ST_RUN  = 6'h01,
		ST_WAIT = 6'h02,
		ST_STOP = 6'h04,
		ST_STAB = 6'h08,
		ST_RSTH = 6'h10,
		ST_RSTR = 6'h20
	} sswc_state_t;

	typedef struct packed {
		logic sub_sel;
		logic sub_en;
		logic main_stop;
	} sswc_cmode_t;

	typedef struct packed {
		logic main_run;
		logic sub_run;
		logic sub_sys;
	} sswc_osc_t;

endpackage

/* File: rtl/sswc_standby.sv */
/*
 * Standby controller: stop and wait modes, wake-up wait, reset recovery.
 * Assumes main_osc_tick is a one-cycle pulse per main oscillator cycle
 * from logic on sys_clk, and irq_request is an enabled pending request.
 */
// The register addresses and the AXI4-Lite register port were left to the implementer.
`timescale 1ns/10ps

module sswc_standby
	import sswc_pkg::*;
#(
	parameter int ADDR_W = 8
) (
	input  wire logic              sys_clk,
	input  wire logic              resetn,
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output logic                   s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output logic                   s_axi_wready,
	output logic [1:0]             s_axi_bresp,
	output logic                   s_axi_bvalid,
	input  wire logic              s_axi_bready,
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output logic                   s_axi_arready,
	output logic [31:0]            s_axi_rdata,
	output logic [1:0]             s_axi_rresp,
	output logic                   s_axi_rvalid,
	input  wire logic              s_axi_rready,
	input  wire logic              stop_instruction,
	input  wire logic              wait_instruction,
	input  wire logic              irq_request,
	input  wire logic              reset_pin_n,
	input  wire logic              main_osc_tick,
	output sswc_osc_t              osc,
	output logic                   cpu_clk_hold,
	output logic                   periph_run,
	output logic                   port_hold,
	output logic                   port_input,
	output logic                   cpu_reset,
	output logic                   irq_accept
);

	if (ADDR_W < 4 || ADDR_W > 32) begin : g_chk
		$error("sswc_standby: ADDR_W out of range");
	end

	// ******************************
	// reset pin synchroniser
	// ******************************
	logic pin_meta;
	logic pin_sync;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			pin_meta <= 1'b1;
			pin_sync <= 1'b1;
		end else begin
			pin_meta <= reset_pin_n;
			pin_sync <= pin_meta;
		end
	end

	// ******************************
	// registers and counters
	// ******************************
	sswc_state_t state;
	sswc_state_t next_state;
	sswc_cmode_t cmode;
	logic        stab_sel;
	logic [7:0]  presc;
	logic [7:0]  timer;
	logic [7:0]  presc_latch;
	logic [7:0]  timer_latch;
	logic [3:0]  pre_div;
	logic [4:0]  rel_cnt;
	logic        div_tick;
	logic        stab_done;
	logic        in_reset;
	logic        wr_fire;
	logic [ADDR_W-1:0] wr_addr;
	logic [31:0] wr_data;
	logic        aw_held;
	logic        w_held;

	function automatic logic ofs_hit(input logic [ADDR_W-1:0] a,
		input logic [7:0] ofs);
		ofs_hit = (a == ADDR_W'(ofs));
	endfunction

	assign in_reset  = (state == ST_RSTH) || (state == ST_RSTR);
	assign div_tick  = (state == ST_STAB) && main_osc_tick &&
		(pre_div == PRESC_DIV_LAST);
	assign stab_done = div_tick && (presc == 8'h00) && (timer == 8'h00);

	// ******************************
	// mode sequencer
	// ******************************
	always_comb begin
		next_state = state;
		if (!pin_sync) begin
			next_state = ST_RSTH;
		end else begin
			unique case (state)
				ST_RSTH: next_state = ST_RSTR;
				ST_RSTR: begin
					if (main_osc_tick && rel_cnt == RST_REL_XIN - 5'h01) begin
						next_state = ST_RUN;
					end
				end
				ST_RUN: begin
					if (stop_instruction) begin
						next_state = ST_STOP;
					end else if (wait_instruction) begin
						next_state = ST_WAIT;
					end
				end
				ST_WAIT: begin
					if (irq_request) begin
						next_state = ST_RUN;
					end
				end
				ST_STOP: begin
					if (irq_request) begin
						next_state = ST_STAB;
					end
				end
				ST_STAB: begin
					if (stab_done) begin
						next_state = ST_RUN;
					end
				end
				default: next_state = ST_RSTH;
			endcase
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			state <= ST_RSTH;
		end else begin
			state <= next_state;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn || state != ST_RSTR) begin
			rel_cnt <= 5'h00;
		end else if (main_osc_tick) begin
			rel_cnt <= rel_cnt + 5'h01;
		end
	end

	// ******************************
	// wake-up wait counter
	// ******************************
	// main tick only
	always_ff @(posedge sys_clk) begin
		if (!resetn || state != ST_STAB) begin
			pre_div <= 4'h0;
		end else if (main_osc_tick) begin
			pre_div <= pre_div + 4'h1;
		end
	end

	// latches are overwritten on stop entry when stab_sel is 0, so software must reload them
	always_ff @(posedge sys_clk) begin
		if (!resetn || in_reset) begin
			presc_latch <= STOP_PRESC_LOAD;
			timer_latch <= STOP_TIMER_LOAD;
			presc       <= STOP_PRESC_LOAD;
			timer       <= STOP_TIMER_LOAD;
		end else if (state == ST_RUN && next_state == ST_STOP && !stab_sel) begin
			presc_latch <= STOP_PRESC_LOAD;
			timer_latch <= STOP_TIMER_LOAD;
			presc       <= STOP_PRESC_LOAD;
			timer       <= STOP_TIMER_LOAD;
		end else if (wr_fire && ofs_hit(wr_addr, TLATCH_OFS)) begin
			presc_latch <= wr_data[TL_PRESC_LSB +: 8];
			timer_latch <= wr_data[TL_TIMER_LSB +: 8];
			presc       <= wr_data[TL_PRESC_LSB +: 8];
			timer       <= wr_data[TL_TIMER_LSB +: 8];
		end else if (div_tick) begin
			if (presc == 8'h00) begin
				presc <= presc_latch;
				timer <= (timer == 8'h00) ? timer_latch : timer - 8'h01;
			end else begin
				presc <= presc - 8'h01;
			end
		end
	end

	// ******************************
	// setup and clock mode registers
	// ******************************
	// special registers reset
	always_ff @(posedge sys_clk) begin
		if (!resetn || in_reset) begin
			stab_sel <= MISC_RST;
		end else if (wr_fire && ofs_hit(wr_addr, MISC_OFS)) begin
			stab_sel <= wr_data[STAB_SEL_BIT];
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn || in_reset) begin
			cmode <= CMODE_RST;
		end else if (wr_fire && ofs_hit(wr_addr, CMODE_OFS)) begin
			cmode.main_stop <= wr_data[CM_MAIN_STOP];
			cmode.sub_en    <= wr_data[CM_SUB_EN];
			cmode.sub_sel   <= wr_data[CM_SUB_SEL];
		end
	end

	// ******************************
	// outputs
	// ******************************
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			osc          <= '{main_run: 1'b1, sub_run: 1'b0, sub_sys: 1'b0};
			cpu_clk_hold <= 1'b0;
			periph_run   <= 1'b0;
			port_hold    <= 1'b0;
			port_input   <= 1'b1;
			cpu_reset    <= 1'b1;
			irq_accept   <= 1'b0;
		end else begin
			osc.main_run <= (next_state != ST_STOP) &&
				(!cmode.main_stop || next_state == ST_RSTH);
			osc.sub_run  <= (next_state != ST_STOP) && cmode.sub_en &&
				(next_state != ST_RSTH);
			osc.sub_sys  <= cmode.sub_sel && (next_state != ST_RSTH);
			cpu_clk_hold <= (next_state == ST_WAIT) ||
				(next_state == ST_STOP) || (next_state == ST_STAB);
			periph_run   <= (next_state == ST_RUN) || (next_state == ST_WAIT);
			port_hold    <= (next_state == ST_WAIT) ||
				(next_state == ST_STOP) || (next_state == ST_STAB);
			port_input   <= (next_state == ST_RSTH) || (next_state == ST_RSTR);
			cpu_reset    <= (next_state == ST_RSTH) || (next_state == ST_RSTR);
			irq_accept   <= next_state == ST_RUN &&
				(state == ST_WAIT || state == ST_STAB);
		end
	end

	// ******************************
	// AXI4-Lite slave
	// ******************************
	assign wr_fire = aw_held && w_held && !s_axi_bvalid;

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_awready <= 1'b1;
			aw_held       <= 1'b0;
			wr_addr       <= '0;
		end else if (s_axi_awvalid && s_axi_awready) begin
			s_axi_awready <= 1'b0;
			aw_held       <= 1'b1;
			wr_addr       <= s_axi_awaddr;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_awready <= 1'b1;
			aw_held       <= 1'b0;
		end
	end

	// byte lanes other than lane 0 and 1 carry no bits of use here
	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_wready <= 1'b1;
			w_held       <= 1'b0;
			wr_data      <= '0;
		end else if (s_axi_wvalid && s_axi_wready) begin
			s_axi_wready <= 1'b0;
			w_held       <= 1'b1;
			for (int i = 0; i < 4; i++) begin
				wr_data[8*i +: 8] <= s_axi_wstrb[i] ? s_axi_wdata[8*i +: 8]
					: 8'h00;
			end
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_wready <= 1'b1;
			w_held       <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= RESP_OKAY;
		end else if (wr_fire) begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= (ofs_hit(wr_addr, MISC_OFS) ||
				ofs_hit(wr_addr, CMODE_OFS) ||
				ofs_hit(wr_addr, TLATCH_OFS)) ? RESP_OKAY : RESP_SLVERR;
		end else if (s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!resetn) begin
			s_axi_arready <= 1'b1;
			s_axi_rvalid  <= 1'b0;
			s_axi_rdata   <= 32'h0000_0000;
			s_axi_rresp   <= RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid  <= 1'b1;
			s_axi_rresp   <= RESP_OKAY;
			if (ofs_hit(s_axi_araddr, MISC_OFS)) begin
				s_axi_rdata <= {31'h0, stab_sel};
			end else if (ofs_hit(s_axi_araddr, CMODE_OFS)) begin
				s_axi_rdata <= {29'h0, cmode};
			end else if (ofs_hit(s_axi_araddr, TLATCH_OFS)) begin
				s_axi_rdata <= {16'h0, timer_latch, presc_latch};
			end else if (ofs_hit(s_axi_araddr, STAT_OFS)) begin
				s_axi_rdata <= {10'h0, state, timer, presc};
			end else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= RESP_SLVERR;
			end
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid  <= 1'b0;
			s_axi_arready <= 1'b1;
		end
	end

	// ******************************
	// assertions
	// ******************************
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!resetn);

	a_stop_load_ff: assert property (state == ST_RUN && stop_instruction &&
		pin_sync && !stab_sel |=> presc == 8'hFF && timer == 8'h01)
		else $error("stop entry did not load wake-up counters");

	a_stop_keep_val: assert property (state == ST_RUN && stop_instruction &&
		pin_sync && stab_sel && !(wr_fire && ofs_hit(wr_addr, TLATCH_OFS))
		|=> $stable(presc) && $stable(timer))
		else $error("stop entry changed counters with select bit set");

	a_stop_osc_off: assert property (state == ST_STOP |->
		!osc.main_run && !osc.sub_run && cpu_clk_hold && !periph_run)
		else $error("oscillator or clock running in stop");

	a_stab_resume: assert property (state == ST_STAB && pin_sync |=>
		(state == ST_RUN) == $past(stab_done))
		else $error("wake from stop not tied to timer underflow");

	// wait state outputs
	// osc is registered from last cycle's clock mode
	a_wait_outputs: assert property (state == ST_WAIT |->
		cpu_clk_hold && periph_run && port_hold &&
		osc.main_run != $past(cmode.main_stop))
		else $error("wait mode outputs wrong");

	a_wait_irq_wake: assert property (state == ST_WAIT && irq_request &&
		pin_sync |=> state == ST_RUN && irq_accept && !cpu_clk_hold)
		else $error("interrupt did not end wait mode");

	a_reset_prio: assert property (!pin_sync && irq_request |=>
		state == ST_RSTH && port_input && cpu_reset && !irq_accept)
		else $error("interrupt taken over reset");

	a_rel_time: assert property ($past(state == ST_RSTR) &&
		state == ST_RUN
		|-> $past(rel_cnt) == RST_REL_XIN - 5'h01 && $past(main_osc_tick))
		else $error("reset released at wrong tick count");

	a_cmode_reset: assert property (state == ST_RSTR |=>
		cmode == CMODE_RST && osc.main_run && !osc.sub_sys)
		else $error("clock mode not back to main after reset");

	c_wait_wake: cover property (state == ST_WAIT ##1 state == ST_RUN);
	c_stop_wake: cover property (state == ST_STAB ##1 state == ST_RUN);
	c_wait_reset: cover property (state == ST_WAIT ##1 state == ST_RSTH);
	c_stop_reset: cover property (state == ST_STAB ##1 state == ST_RSTH);

endmodule

/* File: testbench/sswc_far_end.sv */
/*
 * Far-end model of the standby controller: CPU instruction strobes,
 * the interrupt request, the external reset pin and the main tick.
 * Assumes its tasks are called just after a rising sys_clk edge.
 */
`timescale 1ns/10ps

module sswc_far_end #(
	parameter int TICK_DIV = 2
) (
	input  wire logic sys_clk,
	output logic      stop_instruction,
	output logic      wait_instruction,
	output logic      irq_request,
	output logic      reset_pin_n,
	output logic      main_osc_tick
);
	int div_cnt = 0;

	initial begin
		stop_instruction = 1'b0;
		wait_instruction = 1'b0;
		irq_request = 1'b0;
		reset_pin_n = 1'b1;
	end

	// free-running, since the block counts ticks even with main stopped
	always @(posedge sys_clk) begin
		div_cnt <= (div_cnt == TICK_DIV - 1) ? 0 : div_cnt + 1;
		main_osc_tick <= (div_cnt == 0);
	end

	task automatic exec(input logic is_stop);
		stop_instruction <= is_stop;
		wait_instruction <= !is_stop;
		@(posedge sys_clk);
		stop_instruction <= 1'b0;
		wait_instruction <= 1'b0;
	endtask

	// request raised only once the standby mode is entered
	// request lands two edges after the pin, matching the pin synchroniser
	task automatic pin_set(input logic lvl, input logic with_irq);
		reset_pin_n <= lvl;
		repeat (2) @(posedge sys_clk);
		irq_request <= with_irq;
		@(posedge sys_clk);
		irq_request <= 1'b0;
	endtask

	// callers hold the pin low through these ticks
	task automatic wait_ticks(input int n);
		repeat (n) begin
			do @(posedge sys_clk); while (main_osc_tick !== 1'b1);
		end
	endtask
endmodule

/* File: testbench/tb_top.sv */
/*
 * Bench for the standby controller: registers over AXI4-Lite, wait and
 * stop entry and wake-up, pin reset, release timing, reset priority.
 * Assumes the far-end model drives pins, strobes and main ticks.
 */
`timescale 1ns/10ps

module tb_top
	import sswc_pkg::*;
;
	logic        sys_clk, resetn, awvalid, awready, wvalid, wready;
	logic        bvalid, bready, arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, d;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp;
	logic        stop_i, wait_i, irq, pin_n, tick;
	logic        cpu_clk_hold, periph_run, port_hold, port_input;
	logic        cpu_reset, irq_accept;
	sswc_osc_t   osc;
	int          errors, cmp_count, n;

	sswc_standby dut (
		.sys_clk(sys_clk), .resetn(resetn), .s_axi_awaddr(awaddr),
		.s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr),
		.s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
		.s_axi_rready(rready), .stop_instruction(stop_i),
		.wait_instruction(wait_i), .irq_request(irq),
		.reset_pin_n(pin_n), .main_osc_tick(tick), .osc(osc),
		.cpu_clk_hold(cpu_clk_hold), .periph_run(periph_run),
		.port_hold(port_hold), .port_input(port_input),
		.cpu_reset(cpu_reset), .irq_accept(irq_accept));

	sswc_far_end far (
		.sys_clk(sys_clk), .stop_instruction(stop_i),
		.wait_instruction(wait_i), .irq_request(irq),
		.reset_pin_n(pin_n), .main_osc_tick(tick));

	// ******************************
	// shared tasks
	// ******************************
	task automatic check(input logic [31:0] seen, input logic [31:0] exp,
		input string msg);
		cmp_count++;
		if (seen !== exp) begin
			errors++;
			$display("unexpected at %0t: %s got %h want %h",
				$time, msg, seen, exp);
		end
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v,
		input logic [1:0] er);
		logic pa;
		logic pw;
		pa = 1'b1;
		pw = 1'b1;
		awaddr <= a;
		wdata <= v;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (pa || pw) begin
			@(posedge sys_clk);
			if (pa && awready === 1'b1) begin
				pa = 1'b0;
				awvalid <= 1'b0;
			end
			if (pw && wready === 1'b1) begin
				pw = 1'b0;
				wvalid <= 1'b0;
			end
		end
		// bready stays up between writes, so back-to-back calls never
		// lower and raise it in one time step
		do @(posedge sys_clk); while (bvalid !== 1'b1);
		check({30'h0, bresp}, {30'h0, er}, "write response");
	endtask

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] m,
		input logic [31:0] e, input logic [1:0] er);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do @(posedge sys_clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge sys_clk); while (rvalid !== 1'b1);
		d = rdata;
		check({30'h0, rresp}, {30'h0, er}, "read response");
		check(d & m, e, "read data");
	endtask

	task automatic release_chk();
		far.pin_set(1'b1, 1'b0);
		n = 0;
		while (cpu_reset !== 1'b0 && n < 100) begin
			@(posedge sys_clk);
			if (tick) n++;
		end
		check({31'h0, n * 10 >= RST_REL_MIN_TENTHS &&
			n * 10 <= RST_REL_MAX_TENTHS}, 32'h1, "release ticks");
	endtask

	task automatic stop_case(input logic [31:0] sel, input logic [31:0] tl,
		input logic [31:0] exp_tl, input int lo, input int hi);
		axi_wr(CMODE_OFS, 32'h2, RESP_OKAY);
		axi_wr(TLATCH_OFS, tl, RESP_OKAY);
		axi_wr(MISC_OFS, sel, RESP_OKAY);
		far.exec(1'b1);
		repeat (2) @(posedge sys_clk);
		check({27'h0, osc, cpu_clk_hold, periph_run}, 32'h2, "stop");
		rd_chk(TLATCH_OFS, 32'hFFFF, exp_tl, RESP_OKAY);
		far.pin_set(1'b1, 1'b1);
		n = 0;
		while (irq_accept !== 1'b1 && n < 20000) begin
			@(posedge sys_clk);
			if (tick) n++;
		end
		check({31'h0, n >= lo && n <= hi}, 32'h1, "wake ticks");
		@(posedge sys_clk);
		check({27'h0, osc, cpu_clk_hold, periph_run}, 32'h19, "wake");
		rd_chk(CMODE_OFS, 32'h7, 32'h2, RESP_OKAY);
		axi_wr(TLATCH_OFS, 32'h01FF, RESP_OKAY);
		axi_wr(CMODE_OFS, 32'h0, RESP_OKAY);
	endtask

	task automatic end_of_test();
		$display("comparisons %0d mismatches %0d", cmp_count, errors);
		if (errors == 0 && cmp_count > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ******************************
	// clock, watchdog, tests
	// ******************************
	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	// stop wake alone needs about 16400 cycles
	initial begin
		repeat (40000) @(posedge sys_clk);
		errors++;
		end_of_test();
	end

	initial begin
		errors = 0;
		cmp_count = 0;
		resetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h0;
		{awaddr, araddr, wdata} = 48'h0;
		wstrb = 4'hF;
		repeat (16) @(posedge sys_clk);
		resetn <= 1'b1;
		n = 0;
		while (cpu_reset !== 1'b0 && n < 200) begin
			@(posedge sys_clk);
			n++;
		end
		check({27'h0, osc, cpu_clk_hold, periph_run}, 32'h11, "run");
		rd_chk(MISC_OFS, 32'h1, 32'h0, RESP_OKAY);
		rd_chk(TLATCH_OFS, 32'hFFFF, 32'h01FF, RESP_OKAY);
		rd_chk(STAT_OFS, 32'h3F_0000, 32'h1_0000, RESP_OKAY);
		rd_chk(8'h10, 32'hFFFF_FFFF, 32'h0, RESP_SLVERR);
		axi_wr(STAT_OFS, 32'h0, RESP_SLVERR);
		// lane 1 strobed off: timer latch takes zero
		wstrb <= 4'h1;
		axi_wr(TLATCH_OFS, 32'h0203, RESP_OKAY);
		wstrb <= 4'hF;
		rd_chk(TLATCH_OFS, 32'hFFFF, 32'h0003, RESP_OKAY);
		$display("test registers done");
		far.exec(1'b0);
		repeat (2) @(posedge sys_clk);
		check({26'h0, osc, cpu_clk_hold, periph_run, port_hold}, 32'h27,
			"wait");
		rd_chk(STAT_OFS, 32'h3F_0000, 32'h2_0000, RESP_OKAY);
		far.pin_set(1'b1, 1'b1);
		n = 0;
		while (irq_accept !== 1'b1 && n < 50) begin
			@(posedge sys_clk);
			n++;
		end
		check({30'h0, n <= 1, cpu_clk_hold}, 32'h2, "wait wake");
		$display("test wait done");
		stop_case(32'h0, 32'h0203, 32'h01FF, 7600, 8400);
		stop_case(32'h1, 32'h0203, 32'h0203, 1, 1000);
		$display("test stop done");
		axi_wr(CMODE_OFS, 32'h7, RESP_OKAY);
		// osc follows the register one edge after the write lands
		@(posedge sys_clk);
		check({29'h0, osc}, 32'h3, "sub clock");
		far.exec(1'b0);
		far.pin_set(1'b0, 1'b0);
		far.wait_ticks(40);
		check({27'h0, osc, port_input, cpu_clk_hold}, 32'h12,
			"pin reset");
		release_chk();
		rd_chk(CMODE_OFS, 32'h7, 32'h0, RESP_OKAY);
		$display("test pin reset done");
		far.exec(1'b0);
		far.pin_set(1'b0, 1'b1);
		n = 0;
		repeat (30) begin
			@(posedge sys_clk);
			if (irq_accept) n++;
		end
		check(n, 32'h0, "accept under reset");
		check({31'h0, port_input}, 32'h1, "ports input");
		far.wait_ticks(24);
		release_chk();
		$display("test reset priority done");
		end_of_test();
	end
endmodule
